// ---- verilog/eba_arbiter.sv ----
// external bus arbitration, recovery idle cycle and select space decode
// assumes an outside sequencer runs each external cycle and pulses cyc_done at its end
`timescale 1ns/1ns
module eba_arbiter (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        ext_master_request_n,
    input  wire logic        bus_req,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_last,
    input  wire logic        cyc_done,
    input  wire logic [3:0]  space_enable,
    input  wire logic [63:0] space_base_value,
    input  wire logic [63:0] space_mask_value,
    input  wire logic [9:0]  space_width,
    input  wire logic [14:0] space_wait,
    input  wire logic [4:0]  select_recovery_enable,
    input  wire logic [3:0]  port4_control,
    input  wire logic [3:0]  port4_function,
    output logic             bus_gnt,
    output logic             ext_master_grant_n,
    output logic             pins_drive_en,
    output logic             pullup_en,
    output logic [3:0]       space_select_n,
    output logic [3:0]       select_oe,
    output logic [2:0]       cur_space,
    output logic [1:0]       cur_width,
    output logic [2:0]       cur_wait,
    output logic             recovery_active
);
    logic                    req_meta_r;
    logic                    req_sync_r;
    logic [3:0]              hit;
    logic [2:0]              pick;
    eba_pkg::eba_state_t     state_r;
    eba_pkg::eba_state_t     state_nxt;
    logic                    mid_r;
    logic                    mid_nxt;
    logic                    last_r;
    logic                    last_nxt;
    logic [2:0]              space_r;
    logic [2:0]              space_nxt;
    logic                    gnt_c;
    logic                    grant_n_r;
    logic                    grant_n_nxt;
    logic                    drive_r;
    logic                    drive_nxt;
    logic [3:0]              sel_n_r;
    logic [3:0]              sel_n_nxt;
    logic [3:0]              sel_oe_r;
    logic [3:0]              sel_oe_nxt;
    logic [1:0]              width_r;
    logic [1:0]              width_nxt;
    logic [2:0]              wait_r;
    logic [2:0]              wait_nxt;
    logic                    recov_r;
    logic                    recov_nxt;
    logic [3:0]              sel_role;

    // request pin is asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_meta_r <= 1'b1;
            req_sync_r <= 1'b1;
        end else begin
            req_meta_r <= ext_master_request_n;
            req_sync_r <= req_meta_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < eba_pkg::NUM_SPACES; gi++) begin : g_space
            eba_space_match #(
                .MASK_LSB((gi < 2) ? eba_pkg::MASK_LSB_01 : eba_pkg::MASK_LSB_23)
            ) u_match (
                .addr   (bus_addr),
                .enable (space_enable[gi]),
                .base   (space_base_value[gi*eba_pkg::BASE_W +: eba_pkg::BASE_W]),
                .mask   (space_mask_value[gi*eba_pkg::BASE_W +: eba_pkg::BASE_W]),
                .hit    (hit[gi])
            );
        end
    endgenerate

    assign pick     = eba_pkg::eba_pick_space(hit);
    assign sel_role = port4_control & port4_function;

    // only external-area cycles pass through here; internal rom, ram and registers
    // never wait on this state machine, and no path leads from the pins inward
    always_comb begin
        state_nxt = state_r;
        mid_nxt   = mid_r;
        last_nxt  = last_r;
        space_nxt = space_r;
        gnt_c     = 1'b0;
        case (state_r)
            eba_pkg::EBA_IDLE: begin
                // outside request wins at a break, but back-to-back cycles chained through EBA_DUMMY never reach it and can starve it
                if (!req_sync_r && !mid_r) begin
                    state_nxt = eba_pkg::EBA_GRANTED;
                end else if (bus_req) begin
                    gnt_c     = 1'b1;
                    state_nxt = eba_pkg::EBA_CYCLE;
                    space_nxt = pick;
                    last_nxt  = bus_last;
                end
            end
            eba_pkg::EBA_CYCLE: begin
                if (cyc_done) begin
                    mid_nxt = !last_r;
                    if (bus_req && select_recovery_enable[space_r]) begin
                        // next cycle is committed here, so a request seen in the
                        // idle clock waits for it
                        gnt_c     = 1'b1;
                        state_nxt = eba_pkg::EBA_DUMMY;
                        space_nxt = pick;
                        last_nxt  = bus_last;
                    end else begin
                        state_nxt = eba_pkg::EBA_IDLE;
                    end
                end
            end
            eba_pkg::EBA_DUMMY: begin
                state_nxt = eba_pkg::EBA_CYCLE;
            end
            eba_pkg::EBA_GRANTED: begin
                // core and dma external requests are held off here
                if (req_sync_r) begin
                    state_nxt = eba_pkg::EBA_RELEASE;
                end
            end
            eba_pkg::EBA_RELEASE: begin
                state_nxt = eba_pkg::EBA_IDLE;
            end
            default: begin
                state_nxt = eba_pkg::EBA_IDLE;
            end
        endcase
    end

    always_comb begin
        grant_n_nxt = (state_nxt != eba_pkg::EBA_GRANTED);
        drive_nxt   = (state_nxt == eba_pkg::EBA_IDLE) ||
                      (state_nxt == eba_pkg::EBA_CYCLE) ||
                      (state_nxt == eba_pkg::EBA_DUMMY);
        for (int i = 0; i < eba_pkg::NUM_SPACES; i++) begin
            sel_n_nxt[i]  = !((state_nxt == eba_pkg::EBA_CYCLE) &&
                              (space_nxt == 3'(i)) && sel_role[i]);
            sel_oe_nxt[i] = sel_role[i] && drive_nxt;
        end
        width_nxt = space_width[space_nxt*eba_pkg::WIDTH_W +: eba_pkg::WIDTH_W];
        wait_nxt  = space_wait[space_nxt*eba_pkg::WAIT_W +: eba_pkg::WAIT_W];
        recov_nxt = (state_nxt == eba_pkg::EBA_DUMMY);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r   <= eba_pkg::EBA_IDLE;
            mid_r     <= 1'b0;
            last_r    <= 1'b1;
            space_r   <= eba_pkg::OTHER_SPACE;
            grant_n_r <= 1'b1;
            drive_r   <= 1'b1;
            sel_n_r   <= 4'hf;
            sel_oe_r  <= 4'h0;
            width_r   <= 2'h0;
            wait_r    <= 3'h0;
            recov_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            mid_r     <= mid_nxt;
            last_r    <= last_nxt;
            space_r   <= space_nxt;
            grant_n_r <= grant_n_nxt;
            drive_r   <= drive_nxt;
            sel_n_r   <= sel_n_nxt;
            sel_oe_r  <= sel_oe_nxt;
            width_r   <= width_nxt;
            wait_r    <= wait_nxt;
            recov_r   <= recov_nxt;
        end
    end

    assign bus_gnt            = gnt_c;
    assign ext_master_grant_n = grant_n_r;
    assign pins_drive_en      = drive_r;
    assign pullup_en          = !drive_r;
    assign space_select_n     = sel_n_r;
    assign select_oe          = sel_oe_r;
    assign cur_space          = space_r;
    assign cur_width          = width_r;
    assign cur_wait           = wait_r;
    assign recovery_active    = recov_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_dummy_then_cycle;
        (state_r == eba_pkg::EBA_DUMMY) ##1 (state_r == eba_pkg::EBA_CYCLE);
    endsequence

    property p_dummy_one_clock;
        (state_r == eba_pkg::EBA_CYCLE) && cyc_done && bus_req &&
            select_recovery_enable[space_r] |=> s_dummy_then_cycle;
    endproperty
    a_dummy_one_clock: assert property (p_dummy_one_clock)
        else $error("recovery idle not exactly one clock");

    property p_grant_at_break;
        $fell(ext_master_grant_n) |->
            $past(state_r == eba_pkg::EBA_IDLE) && !$past(mid_r) && !$past(req_sync_r);
    endproperty
    a_grant_at_break: assert property (p_grant_at_break)
        else $error("grant asserted outside a cycle break");

    property p_sizing_no_grant;
        (state_r == eba_pkg::EBA_IDLE) && mid_r |=> ext_master_grant_n;
    endproperty
    a_sizing_no_grant: assert property (p_sizing_no_grant)
        else $error("grant given inside a sized transfer");

    property p_float_on_grant;
        !ext_master_grant_n |-> !pins_drive_en && pullup_en && (select_oe == 4'h0);
    endproperty
    a_float_on_grant: assert property (p_float_on_grant)
        else $error("pins driven while outside master owns bus");

    property p_stall_when_granted;
        !ext_master_grant_n |-> !bus_gnt;
    endproperty
    a_stall_when_granted: assert property (p_stall_when_granted)
        else $error("external access accepted while bus is handed over");

    property p_dummy_holds_bus;
        (state_r == eba_pkg::EBA_DUMMY) |=> ext_master_grant_n [*2];
    endproperty
    a_dummy_holds_bus: assert property (p_dummy_holds_bus)
        else $error("bus released before committed cycle ran");

    property p_release;
        (state_r == eba_pkg::EBA_GRANTED) && req_sync_r |=> ext_master_grant_n;
    endproperty
    a_release: assert property (p_release)
        else $error("grant not dropped after request returned high");

    property p_drive_after_grant_high;
        $rose(pins_drive_en) |-> ext_master_grant_n && $past(ext_master_grant_n);
    endproperty
    a_drive_after_grant_high: assert property (p_drive_after_grant_high)
        else $error("pins driven again before grant went high");

    property p_select_shown;
        (state_r == eba_pkg::EBA_CYCLE) && (space_r < eba_pkg::OTHER_SPACE) &&
            sel_role[space_r[1:0]] |-> !space_select_n[space_r[1:0]];
    endproperty
    a_select_shown: assert property (p_select_shown)
        else $error("matching space select not asserted");

    property p_select_role;
        (space_select_n != 4'hf) |-> ((~space_select_n & ~sel_role) == 4'h0);
    endproperty
    a_select_role: assert property (p_select_role)
        else $error("select asserted on a pin not set to select role");
endmodule // eba_arbiter

// ---- verilog/eba_pkg.sv ----
// constants, state type and helpers for the external bus arbiter with select decode
// assumes a single core_clk domain and a bus sequencer outside that times each cycle
// Functional notes
// - with recovery enabled, one idle clock separates back-to-back external cycles.
// - bus ownership is traded using only active-low request and grant lines.
// - the outside master gets the external pins, never internal memories or buses.
// - core and dma keep internal rom, ram and register access throughout.
// - core or dma external access stalls while the outside master owns the bus.
// - request is sampled only at a break between cycles; grant drives low.
// - on grant, address, data and strobes float; select and control pins pull up.
// - in a sized transfer only the final cycle's end is a grant point.
// - a request during a recovery idle waits until the started cycle ends.
// - after request returns high, grant goes high and the device retakes the bus.
// - four decoded spaces plus a remaining space, each with width, wait, idle settings.
// - each decoded space has a master enable alongside its width, wait and idle settings.
// - each cycle compares address to each base, skipping masked bits; match selects.
// - base gives address bits 31 to 16; lower bits are zero, 64 kilobyte steps.
// - select pins show only when port control and function pick the select role.
// - mask bit zero compares that address bit, mask bit one skips it.
// - spaces 0 and 1 mask bits 29 to 14, spaces 2 and 3 bits 30 to 15.

package eba_pkg;
    localparam int ADDR_W       = 32;
    localparam int BASE_W       = 16;
    localparam int NUM_SPACES   = 4;
    localparam int NUM_ALL      = 5;
    localparam int SPACE_W      = 3;
    localparam int WIDTH_W      = 2;
    localparam int WAIT_W       = 3;
    localparam int CMP_LSB      = 14;
    localparam int CMP_W        = 18;
    localparam int BASE_LSB     = 16;
    localparam int MASK_LSB_01  = 14;
    localparam int MASK_LSB_23  = 15;
    localparam logic [SPACE_W-1:0] OTHER_SPACE = 3'h4;

    typedef enum logic [2:0] {
        EBA_IDLE,
        EBA_CYCLE,
        EBA_DUMMY,
        EBA_GRANTED,
        EBA_RELEASE
    } eba_state_t;

    // lowest numbered matching space wins when settings overlap
    function automatic logic [SPACE_W-1:0] eba_pick_space(input logic [NUM_SPACES-1:0] hit);
        logic [SPACE_W-1:0] s;
        s = OTHER_SPACE;
        for (int i = NUM_SPACES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                s = SPACE_W'(i);
            end
        end
        return s;
    endfunction
endpackage

// ---- verilog/eba_space_match.sv ----
// address comparator for one decoded select space
// assumes base, mask and enable come from configuration that is stable during a cycle
`timescale 1ns/1ns
module eba_space_match #(
    parameter int MASK_LSB = 14
) (
    input  wire logic [31:0] addr,
    input  wire logic        enable,
    input  wire logic [15:0] base,
    input  wire logic [15:0] mask,
    output logic             hit
);
    logic [eba_pkg::CMP_W-1:0] ignore;
    logic [eba_pkg::CMP_W-1:0] start;
    logic [eba_pkg::CMP_W-1:0] diff;

    always_comb begin
        // mask covers a 16-bit window whose low end depends on the space pair
        ignore = {2'h0, mask} << (MASK_LSB - eba_pkg::CMP_LSB);
        // start address has zero below bit 16
        start  = {base, 2'h0};
        diff   = addr[eba_pkg::ADDR_W-1:eba_pkg::CMP_LSB] ^ start;
        hit    = enable && ((diff & ~ignore) == '0);
    end
endmodule // eba_space_match

// ---- test/eba_ext_master.sv ----
// outside bus master model facing the arbiter request and grant pins
// assumes one core_clk domain; pins change by nba on the rising edge
`timescale 1ns/1ns
module eba_ext_master (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [7:0] hold_len,
    input  wire logic       ext_master_grant_n,
    output logic            ext_master_request_n
);
    logic [7:0] cnt_r;
    initial begin
        ext_master_request_n = 1'b1;
        cnt_r = 8'h00;
    end
    // a new request waits for grant high so a late grant is never mistaken for ours
    always @(posedge core_clk) begin
        if (ext_master_request_n && ext_master_grant_n && go) begin
            ext_master_request_n <= 1'b0;
        end else if (!ext_master_request_n && !ext_master_grant_n) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == hold_len) begin
                ext_master_request_n <= 1'b1;
                cnt_r <= 8'h00;
            end
        end
    end
endmodule // eba_ext_master

// ---- test/eba_arbiter_bench.sv ----
// self-checking bench for the arbiter, select decode and recovery idle clock
// assumes a 100 MHz core_clk; inputs change on falling edges
`timescale 1ns/1ns
module eba_arbiter_bench;
    logic        core_clk, srst, req_n, bus_req, bus_last, cyc_done, go;
    logic        bus_gnt, ext_master_grant_n, pins_drive_en, pullup_en, recovery_active;
    logic [31:0] bus_addr;
    logic [3:0]  space_enable, port4_control, port4_function, space_select_n, select_oe;
    logic [63:0] space_base_value, space_mask_value;
    logic [9:0]  space_width;
    logic [14:0] space_wait;
    logic [4:0]  select_recovery_enable;
    logic [2:0]  cur_space, cur_wait;
    logic [1:0]  cur_width;
    int          n_fail, n_tests;
    logic [31:0] adr_tab [7] = '{32'h0001_0000, 32'h0001_4000, 32'h0002_4000, 32'h0010_8000,
                                 32'h0010_4000, 32'h0020_0000, 32'h0001_0004};
    int          sp_tab  [7] = '{0, 4, 1, 2, 4, 4, 0};

    eba_arbiter uut (.core_clk(core_clk), .srst(srst), .ext_master_request_n(req_n),
        .bus_req(bus_req), .bus_addr(bus_addr), .bus_last(bus_last), .cyc_done(cyc_done),
        .space_enable(space_enable), .space_base_value(space_base_value),
        .space_mask_value(space_mask_value), .space_width(space_width),
        .space_wait(space_wait), .select_recovery_enable(select_recovery_enable),
        .port4_control(port4_control), .port4_function(port4_function), .bus_gnt(bus_gnt),
        .ext_master_grant_n(ext_master_grant_n), .pins_drive_en(pins_drive_en),
        .pullup_en(pullup_en), .space_select_n(space_select_n), .select_oe(select_oe),
        .cur_space(cur_space), .cur_width(cur_width), .cur_wait(cur_wait),
        .recovery_active(recovery_active));
    eba_ext_master master (.core_clk(core_clk), .go(go), .hold_len(8'h08),
        .ext_master_grant_n(ext_master_grant_n), .ext_master_request_n(req_n));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wgnt(input logic v);
        int n;
        n = 0;
        while (ext_master_grant_n !== v && n < 20) begin
            @(negedge core_clk);
            #1;
            n++;
        end
        chk(ext_master_grant_n, v);
        if (n == 20) begin
            results();
        end
    endtask

    // holds the request until accepted, then drops it; ends half a clock into the cycle
    task automatic start(input logic [31:0] a, input logic l);
        int n;
        n = 0;
        @(negedge core_clk);
        bus_req = 1'b1;
        bus_addr = a;
        bus_last = l;
        #1;
        while (bus_gnt !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            #1;
            n++;
        end
        if (n == 60) begin
            n_fail++;
            results();
        end
        @(negedge core_clk);
        bus_req = 1'b0;
        #1;
    endtask

    task automatic done(input int d);
        @(negedge core_clk);
        go = 1'b0;
        repeat (d) @(negedge core_clk);
        cyc_done = 1'b1;
        @(negedge core_clk);
        cyc_done = 1'b0;
    endtask

    task automatic chk_dec(input int s);
        // a matched space whose pin is not in the select role keeps its select high
        chk(space_select_n, (s < 4 && port4_control[s] && port4_function[s]) ?
            (~(32'h1 << s) & 32'hf) : 32'hf);
        chk(cur_space, s);
        chk(cur_width, (space_width >> (2 * s)) & 10'h003);
        chk(cur_wait, (space_wait >> (3 * s)) & 15'h0007);
    endtask

    initial begin
        n_fail = 0;
        n_tests = 0;
        srst = 1'b1;
        {bus_req, bus_last, cyc_done, go} = 4'h0;
        bus_addr = 32'h0000_0000;
        space_enable = 4'h7;
        space_base_value = {16'h0020, 16'h0010, 16'h0002, 16'h0001};
        space_mask_value = {16'h0000, 16'h0001, 16'h0001, 16'h0000};
        space_width = 10'h239;
        space_wait = 15'h58d1;
        select_recovery_enable = 5'h00;
        port4_control = 4'hf;
        port4_function = 4'hb;
        repeat (8) @(negedge core_clk);
        chk({ext_master_grant_n, pins_drive_en, pullup_en}, 32'h6);
        chk({space_select_n, select_oe, cur_space}, 32'h784);
        srst = 1'b0;
        @(negedge core_clk);
        #1;
        chk(select_oe, 32'hb);
        // decode table: masks, window edges, disabled space and low bits
        for (int i = 0; i < 7; i++) begin
            start(adr_tab[i], 1'b1);
            chk_dec(sp_tab[i]);
            done(1);
        end
        // back to back with recovery, outside request arriving at the break
        select_recovery_enable = 5'h01;
        start(32'h0001_0000, 1'b1);
        @(negedge core_clk);
        cyc_done = 1'b1;
        bus_req = 1'b1;
        go = 1'b1;
        #1;
        chk(bus_gnt, 1);
        @(negedge core_clk);
        {cyc_done, bus_req, go} = 3'h0;
        #1;
        chk({recovery_active, space_select_n}, 32'h1f);
        @(negedge core_clk);
        #1;
        chk({recovery_active, space_select_n}, 32'h0e);
        repeat (3) @(negedge core_clk);
        #1;
        chk(ext_master_grant_n, 1);
        done(0);
        wgnt(1'b0);
        chk({pins_drive_en, pullup_en, select_oe}, 32'h10);
        @(negedge core_clk);
        bus_req = 1'b1;
        bus_addr = 32'h0010_8000;
        repeat (3) begin
            @(negedge core_clk);
            #1;
            chk(bus_gnt, 0);
        end
        wgnt(1'b1);
        chk({pins_drive_en, bus_gnt}, 32'h0);
        @(negedge core_clk);
        #1;
        chk({pins_drive_en, pullup_en, select_oe, bus_gnt}, 32'h57);
        @(negedge core_clk);
        bus_req = 1'b0;
        #1;
        chk_dec(2);
        done(1);
        // sized transfer: the break after a non-final piece is no grant point
        select_recovery_enable = 5'h00;
        start(32'h0002_4000, 1'b0);
        go = 1'b1;
        done(3);
        start(32'h0002_4000, 1'b1);
        chk(ext_master_grant_n, 1);
        chk_dec(1);
        done(1);
        wgnt(1'b0);
        wgnt(1'b1);
        repeat (2) @(negedge core_clk);
        results();
    end
endmodule // eba_arbiter_bench
